// ### common/qrs_pkg.sv
// Functional notes
// - supply ready starts switching via soft-start
// - soft-start limit from internal reference
// - reference steps every 4ms, 12ms total
// - overload detection suppressed during soft-start
// - valley-skip counter sets the valley to turn on in
// - valley-skip counter stays within 1..7
// - steps beyond range are ignored
// - one step per 48ms update period
// - always below low threshold: count up
// - above low, never high: hold
// - above high, never fast: count down
// - above fast threshold: force 1 next period
// - turn on at count match below valley threshold
// - max-period timer also turns switch on
// - burst mode disables normal turn-on
// - current comparator trip turns switch off
// - ignore current comparator 330ns after turn-on
// - supply ready disables start-up charging cell
// - burst or latch may re-enable start-up cell
// - leaving burst forces counter to 1
`default_nettype none
package qrs_pkg;

    localparam int unsigned CLK_HZ = 125_000_000;
    localparam int unsigned CLK_NS = 8;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int unsigned SS_STEP_MS = 4;
    localparam int unsigned SS_TOTAL_MS = 12;
    localparam int unsigned SS_STEPS = SS_TOTAL_MS / SS_STEP_MS;
    localparam int unsigned SS_STEP_CYC = SS_STEP_MS * (CLK_HZ / 1000);
    localparam int unsigned UPD_MS = 48;
    localparam int unsigned UPD_CYC = UPD_MS * (CLK_HZ / 1000);
    localparam int unsigned LEB_NS = 330;
    localparam int unsigned LEB_CYC = (LEB_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned MAX_PERIOD_US = 50;
    localparam int unsigned MAX_PERIOD_CYC = MAX_PERIOD_US * (CLK_HZ / 1000000);

    // ************************************************************
    // valley-skip counter
    // ************************************************************
    localparam logic [2:0] SKIP_MIN = 3'h1;
    localparam logic [2:0] SKIP_MAX = 3'h7;
    localparam logic [2:0] SKIP_RST = 3'h1;

    typedef enum logic [1:0] {
        QRS_IDLE,
        QRS_SOFT,
        QRS_RUN
    } qrs_phase_t;

endpackage
`default_nettype wire

// ### rtl/qrs_soft_start.sv
`timescale 1ns/1ps
`default_nettype none
module qrs_soft_start #(
    parameter int unsigned STEP_CYC = qrs_pkg::SS_STEP_CYC,
    parameter int unsigned STEPS = qrs_pkg::SS_STEPS
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic start,
    output logic active,
    output logic [1:0] step
);
    logic [31:0] cnt_r;
    logic [1:0] step_r;
    logic active_r;

    always_ff @(posedge clock) begin
        if (sys_rst || !start) begin
            active_r <= 1'b0;
            step_r <= 2'h0;
            cnt_r <= 32'h0;
        end else if (!active_r && step_r == 2'h0 && cnt_r == 32'h0) begin
            active_r <= 1'b1;
            cnt_r <= 32'h1;
        end else if (active_r) begin
            if (cnt_r >= STEP_CYC) begin
                cnt_r <= 32'h1;
                if (step_r == 2'(STEPS - 1)) begin
                    active_r <= 1'b0;
                end else begin
                    step_r <= step_r + 2'h1;
                end
            end else begin
                cnt_r <= cnt_r + 32'h1;
            end
        end
    end

    assign active = active_r;
    assign step = step_r;
endmodule
`default_nettype wire

// ### rtl/qrs_skip_counter.sv
`timescale 1ns/1ps
`default_nettype none
module qrs_skip_counter #(
    parameter int unsigned UPD_CYC = qrs_pkg::UPD_CYC
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic above_low,
    input wire logic above_high,
    input wire logic above_fast,
    input wire logic period_start,
    input wire logic burst_exit,
    output logic [2:0] skip
);
    logic [31:0] tick_r;
    logic seen_low_r;
    logic seen_high_r;
    logic seen_fast_r;
    logic fast_pend_r;
    logic [2:0] skip_r;
    logic tick;

    assign tick = (tick_r >= UPD_CYC - 1);

    always_ff @(posedge clock) begin
        if (sys_rst || tick) begin
            tick_r <= 32'h0;
        end else begin
            tick_r <= tick_r + 32'h1;
        end
    end

    // window flags restart each period; an event in the tick cycle still counts
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            seen_low_r <= 1'b0;
            seen_high_r <= 1'b0;
            seen_fast_r <= 1'b0;
        end else if (tick) begin
            seen_low_r <= 1'b0;
            seen_high_r <= 1'b0;
            seen_fast_r <= 1'b0;
        end else begin
            seen_low_r <= seen_low_r | above_low;
            seen_high_r <= seen_high_r | above_high;
            seen_fast_r <= seen_fast_r | above_fast;
        end
    end

    // fast request waits for next switching period; set beats clear
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            fast_pend_r <= 1'b0;
        end else if (above_fast) begin
            fast_pend_r <= 1'b1;
        end else if (period_start) begin
            fast_pend_r <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            skip_r <= qrs_pkg::SKIP_RST;
        end else if (burst_exit) begin
            skip_r <= qrs_pkg::SKIP_MIN;
        end else if (fast_pend_r && period_start) begin
            skip_r <= qrs_pkg::SKIP_MIN;
        end else if (tick) begin
            if (seen_fast_r || above_fast) begin
                skip_r <= skip_r; // fast path owns this case
            end else if (seen_high_r || above_high) begin
                if (skip_r != qrs_pkg::SKIP_MIN) begin
                    skip_r <= skip_r - 3'h1;
                end
            end else if (seen_low_r || above_low) begin
                skip_r <= skip_r;
            end else if (skip_r != qrs_pkg::SKIP_MAX) begin
                skip_r <= skip_r + 3'h1;
            end
        end
    end

    assign skip = skip_r;
endmodule
`default_nettype wire

// ### rtl/qrs_switch_timing.sv
`timescale 1ns/1ps
`default_nettype none
module qrs_switch_timing #(
    parameter int unsigned SS_STEP_CYC = qrs_pkg::SS_STEP_CYC,
    parameter int unsigned UPD_CYC = qrs_pkg::UPD_CYC,
    parameter int unsigned MAX_PERIOD_CYC = qrs_pkg::MAX_PERIOD_CYC,
    parameter int unsigned LEB_CYC = qrs_pkg::LEB_CYC
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic supply_ready,
    input wire logic feedback_above_low,
    input wire logic feedback_above_high,
    input wire logic feedback_above_fast,
    input wire logic valley_detect_input,
    input wire logic current_trip,
    input wire logic burst_active,
    input wire logic protect_latched,
    input wire logic aux_supply_low,
    input wire logic overload_detect,
    output logic gate,
    output logic soft_start_active,
    output logic [1:0] soft_start_step,
    output logic use_internal_reference,
    output logic overload_fault,
    output logic startup_cell_enable,
    output logic [2:0] valley_skip
);
    // ************************************************************
    // soft-start and supply
    // ************************************************************
    logic ss_active;
    logic [1:0] ss_step;
    qrs_pkg::qrs_phase_t phase_r;

    qrs_soft_start #(
        .STEP_CYC(SS_STEP_CYC),
        .STEPS(qrs_pkg::SS_STEPS)
    ) u_soft (
        .clock(clock),
        .sys_rst(sys_rst),
        .start(supply_ready),
        .active(ss_active),
        .step(ss_step)
    );

    always_ff @(posedge clock) begin
        if (sys_rst || !supply_ready) begin
            phase_r <= qrs_pkg::QRS_IDLE;
        end else begin
            case (phase_r)
                qrs_pkg::QRS_IDLE: begin
                    phase_r <= qrs_pkg::QRS_SOFT;
                end
                qrs_pkg::QRS_SOFT: begin
                    if (!ss_active && ss_step != 2'h0) begin
                        phase_r <= qrs_pkg::QRS_RUN;
                    end
                end
                default: begin
                    phase_r <= qrs_pkg::QRS_RUN;
                end
            endcase
        end
    end

    logic running;
    // supply loss stops the gate at once, not one phase update later
    assign running = supply_ready && (phase_r != qrs_pkg::QRS_IDLE);

    logic ss_out_r;
    logic [1:0] ss_step_r;
    logic ovl_r;
    logic cell_r;
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ss_out_r <= 1'b0;
            ss_step_r <= 2'h0;
            ovl_r <= 1'b0;
            cell_r <= 1'b1;
        end else begin
            ss_out_r <= (phase_r == qrs_pkg::QRS_SOFT);
            ss_step_r <= ss_step;
            ovl_r <= overload_detect && (phase_r == qrs_pkg::QRS_RUN);
            if (!supply_ready) begin
                cell_r <= 1'b1;
            end else if ((burst_active || protect_latched) && aux_supply_low) begin
                cell_r <= 1'b1;
            end else begin
                cell_r <= 1'b0;
            end
        end
    end

    assign soft_start_active = ss_out_r;
    assign soft_start_step = ss_step_r;
    assign use_internal_reference = ss_out_r;
    assign overload_fault = ovl_r;
    assign startup_cell_enable = cell_r;

    // ************************************************************
    // valley-skip counter
    // ************************************************************
    logic burst_d_r;
    logic burst_exit;
    logic gate_r;
    logic turn_on;
    logic [2:0] skip;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            burst_d_r <= 1'b0;
        end else begin
            burst_d_r <= burst_active;
        end
    end
    assign burst_exit = burst_d_r && !burst_active;

    qrs_skip_counter #(
        .UPD_CYC(UPD_CYC)
    ) u_skip (
        .clock(clock),
        .sys_rst(sys_rst),
        .above_low(feedback_above_low),
        .above_high(feedback_above_high),
        .above_fast(feedback_above_fast),
        .period_start(turn_on),
        .burst_exit(burst_exit),
        .skip(skip)
    );
    assign valley_skip = skip;

    // ************************************************************
    // switch-on: valley counting and max period
    // ************************************************************
    logic valley_d_r;
    logic valley_edge;
    logic [2:0] zc_cnt_r;
    logic [31:0] off_cnt_r;
    logic max_expired;
    logic match;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            valley_d_r <= 1'b0;
        end else begin
            valley_d_r <= valley_detect_input;
        end
    end
    // input is high while the sensed voltage is under the valley threshold
    assign valley_edge = valley_detect_input && !valley_d_r;

    always_ff @(posedge clock) begin
        if (sys_rst || turn_on) begin
            zc_cnt_r <= 3'h0;
        end else if (!gate_r && valley_edge && zc_cnt_r != qrs_pkg::SKIP_MAX) begin
            zc_cnt_r <= zc_cnt_r + 3'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst || gate_r || !running) begin
            off_cnt_r <= 32'h0;
        end else if (!max_expired) begin
            off_cnt_r <= off_cnt_r + 32'h1;
        end
    end
    // limits low frequency when no valley arrives
    assign max_expired = (off_cnt_r >= MAX_PERIOD_CYC - 1);

    assign match = (zc_cnt_r == skip) && valley_detect_input;
    assign turn_on = running && !gate_r && !burst_active
                     && (match || max_expired);

    // ************************************************************
    // switch-off with blanking
    // ************************************************************
    logic [15:0] leb_cnt_r;
    logic blanked;
    logic turn_off;

    always_ff @(posedge clock) begin
        if (sys_rst || turn_on) begin
            leb_cnt_r <= 16'h0;
        end else if (gate_r && blanked) begin
            leb_cnt_r <= leb_cnt_r + 16'h1;
        end
    end
    assign blanked = (leb_cnt_r < 16'(LEB_CYC));
    assign turn_off = gate_r && current_trip && !blanked;

    // gate flip-flop: off requests win, switch stays off
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            gate_r <= 1'b0;
        end else if (turn_off || !running || burst_active) begin
            gate_r <= 1'b0;
        end else if (turn_on) begin
            gate_r <= 1'b1;
        end
    end
    assign gate = gate_r;
endmodule
`default_nettype wire

// ### test/qrs_switch_timing_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module qrs_switch_timing_chk #(
    parameter int unsigned LEB_CYC = 42
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic supply_ready,
    input wire logic current_trip,
    input wire logic burst_active,
    input wire logic gate,
    input wire logic soft_start_active,
    input wire logic use_internal_reference,
    input wire logic overload_fault,
    input wire logic startup_cell_enable,
    input wire logic [2:0] valley_skip
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    // ************************************************************
    // on-time counter
    // ************************************************************
    logic [15:0] on_cnt_r;
    always_ff @(posedge clock) begin
        if (sys_rst || !gate) begin
            on_cnt_r <= 16'h0000;
        end else begin
            on_cnt_r <= on_cnt_r + 16'h0001;
        end
    end
    property p_blank; $fell(gate) && supply_ready && !burst_active |-> on_cnt_r >= LEB_CYC;
    endproperty
    a_blank: assert property (p_blank) else $error("gate pulse too short");
    property p_trip; gate && current_trip && on_cnt_r > LEB_CYC |=> !gate; endproperty
    a_trip: assert property (p_trip) else $error("trip did not end pulse");
    property p_burst; burst_active && !gate |=> !gate; endproperty
    a_burst: assert property (p_burst) else $error("pulse in burst");
    property p_range; valley_skip >= 3'h1 && valley_skip <= 3'h7; endproperty
    a_range: assert property (p_range) else $error("skip out of range");
    property p_step; valley_skip != $past(valley_skip) |-> valley_skip == 3'h1 ||
        valley_skip - $past(valley_skip) == 3'h1 || $past(valley_skip) - valley_skip == 3'h1;
    endproperty
    a_step: assert property (p_step) else $error("skip jumped");
    property p_exit; $fell(burst_active) |-> ##[1:2] valley_skip == 3'h1; endproperty
    a_exit: assert property (p_exit) else $error("skip not 1 after burst");
    property p_soft; $rose(supply_ready) |-> ##[0:2] soft_start_active; endproperty
    a_soft: assert property (p_soft) else $error("no soft start");
    property p_ref; use_internal_reference == soft_start_active; endproperty
    a_ref: assert property (p_ref) else $error("reference select wrong");
    property p_ovl; soft_start_active |-> !overload_fault; endproperty
    a_ovl: assert property (p_ovl) else $error("overload in soft start");
    property p_cell; !supply_ready |=> startup_cell_enable && !gate; endproperty
    a_cell: assert property (p_cell) else $error("cell off or gate on");
endmodule
bind qrs_switch_timing qrs_switch_timing_chk #(.LEB_CYC(LEB_CYC)) chk_u (
    .clock(clock), .sys_rst(sys_rst), .supply_ready(supply_ready),
    .current_trip(current_trip), .burst_active(burst_active), .gate(gate),
    .soft_start_active(soft_start_active), .use_internal_reference(use_internal_reference),
    .overload_fault(overload_fault), .startup_cell_enable(startup_cell_enable),
    .valley_skip(valley_skip));
`default_nettype wire

// ### test/qrs_analog_model.sv
`timescale 1ns/1ps
`default_nettype none
module qrs_analog_model (
    input wire logic clock,
    input wire logic gate,
    input wire logic valley_en,
    input wire logic [7:0] trip_after,
    output logic current_trip,
    output logic valley_detect_input
);
    // ************************************************************
    // ramp and ring
    // ************************************************************
    logic [7:0] on_r = 8'h00;
    logic [7:0] off_r = 8'h00;
    always @(posedge clock) begin
        on_r <= gate ? on_r + 8'h01 : 8'h00;
        off_r <= gate ? 8'h00 : off_r + 8'h01;
    end
    // ring period 20 cycles, low part of each swing 4 cycles
    assign current_trip = gate && on_r >= trip_after;
    assign valley_detect_input = valley_en && !gate && off_r % 8'h14 >= 8'h10;
endmodule
`default_nettype wire

// ### test/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clock = 1'b0, sys_rst = 1'b1, supply_ready = 1'b0, fb_low = 1'b0, fb_high = 1'b0;
    logic fb_fast = 1'b0, burst_active = 1'b0, protect_latched = 1'b0, aux_supply_low = 1'b0;
    logic overload_detect = 1'b0, valley_en = 1'b0;
    logic [7:0] trip_after = 8'h3C;
    logic current_trip, valley_detect_input, gate, soft_start_active, use_internal_reference;
    logic overload_fault, startup_cell_enable;
    logic [1:0] soft_start_step;
    logic [2:0] valley_skip;
    int errors = 0, checks = 0, n;
    always #4 clock = ~clock;
    qrs_switch_timing #(.SS_STEP_CYC(50), .UPD_CYC(100), .MAX_PERIOD_CYC(200)) dut_u (
        .clock(clock), .sys_rst(sys_rst), .supply_ready(supply_ready),
        .feedback_above_low(fb_low), .feedback_above_high(fb_high),
        .feedback_above_fast(fb_fast), .valley_detect_input(valley_detect_input),
        .current_trip(current_trip), .burst_active(burst_active),
        .protect_latched(protect_latched), .aux_supply_low(aux_supply_low),
        .overload_detect(overload_detect), .gate(gate), .soft_start_active(soft_start_active),
        .soft_start_step(soft_start_step), .use_internal_reference(use_internal_reference),
        .overload_fault(overload_fault), .startup_cell_enable(startup_cell_enable),
        .valley_skip(valley_skip));
    qrs_analog_model far_u (.clock(clock), .gate(gate), .valley_en(valley_en),
        .trip_after(trip_after), .current_trip(current_trip),
        .valley_detect_input(valley_detect_input));
    task automatic cyc(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // waits for a gate level, n holds cycles spent
    task automatic span(input logic lvl);
        n = 0;
        while (gate !== lvl && n < 1000) begin
            cyc(1);
            n++;
        end
    endtask
    task automatic fb(input logic lo, input logic hi, input logic fa, input int k);
        fb_low = lo;
        fb_high = hi;
        fb_fast = fa;
        cyc(k);
    endtask
    task automatic t_soft;
        supply_ready = 1'b1;
        overload_detect = 1'b1;
        cyc(3);
        chk(soft_start_active, 1'b1);
        chk(use_internal_reference, 1'b1);
        chk(startup_cell_enable, 1'b0);
        cyc(60);
        chk(soft_start_step, 2'h1);
        chk(overload_fault, 1'b0);
        cyc(100);
        chk(soft_start_active, 1'b0);
        chk(overload_fault, 1'b1);
        overload_detect = 1'b0;
        $display("soft start done");
    endtask
    task automatic t_pulse;
        trip_after = 8'h00;
        span(1'b1);
        span(1'b0);
        chk(n >= 42 && n <= 45, 1'b1);
        trip_after = 8'h3C;
        span(1'b1);
        span(1'b0);
        chk(n >= 60 && n <= 63, 1'b1);
        span(1'b1);
        chk(n >= 200 && n <= 203, 1'b1);
        $display("pulse timing done");
    endtask
    task automatic t_skip;
        fb(1'b0, 1'b0, 1'b0, 900);
        chk(valley_skip, 3'h7);
        fb(1'b1, 1'b0, 1'b0, 300);
        chk(valley_skip, 3'h7);
        valley_en = 1'b1;
        span(1'b1);
        span(1'b0);
        span(1'b1);
        chk(n >= 135 && n <= 142, 1'b1);
        fb(1'b1, 1'b1, 1'b0, 150);
        chk(valley_skip == 3'h5 || valley_skip == 3'h6, 1'b1);
        // one tick first, so the high seen in the old window is used up
        fb(1'b1, 1'b0, 1'b0, 100);
        n = valley_skip;
        fb(1'b1, 1'b0, 1'b0, 300);
        chk(valley_skip, n[7:0]);
        fb(1'b1, 1'b1, 1'b0, 800);
        chk(valley_skip, 3'h1);
        span(1'b1);
        span(1'b0);
        span(1'b1);
        chk(n >= 15 && n <= 22, 1'b1);
        fb(1'b0, 1'b0, 1'b0, 900);
        fb(1'b1, 1'b1, 1'b1, 300);
        chk(valley_skip, 3'h1);
        $display("skip counter done");
    endtask
    task automatic t_burst;
        fb(1'b0, 1'b0, 1'b0, 900);
        span(1'b0);
        burst_active = 1'b1;
        aux_supply_low = 1'b1;
        cyc(3);
        chk(startup_cell_enable, 1'b1);
        n = 0;
        repeat (300) begin
            cyc(1);
            n += (gate !== 1'b0);
        end
        chk(n, 0);
        chk(valley_skip, 3'h7);
        burst_active = 1'b0;
        aux_supply_low = 1'b0;
        cyc(2);
        chk(valley_skip, 3'h1);
        protect_latched = 1'b1;
        aux_supply_low = 1'b1;
        cyc(2);
        chk(startup_cell_enable, 1'b1);
        supply_ready = 1'b0;
        cyc(2);
        chk(gate, 1'b0);
        $display("burst and cell done");
    endtask
    task automatic results;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        cyc(4);
        sys_rst = 1'b0;
        chk({gate, startup_cell_enable, valley_skip}, 8'h09);
        t_soft;
        t_pulse;
        t_skip;
        t_burst;
        results;
    end
    initial begin
        #200000;
        errors++;
        results;
    end
endmodule
`default_nettype wire
